//--- rtl/tfsb_pkg.sv
// package: register map, field layout, reset values, timing and carrier structs
package tfsb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and duty-cycle window timing
	localparam int CLK_MHZ       = 250;
	localparam int SLICE_TIME_US = 10;
	localparam int SLICE_CYCLES  = SLICE_TIME_US * CLK_MHZ;
	localparam int PCT_SLICES    = 100;

	////////////////////////////////////////////////////////////////////////////////
	// register indexes; byte address is four times the index
	localparam int          IDX_W            = 10;
	localparam logic [9:0]  IDX_ON_TIME      = 10'h04e;
	localparam logic [9:0]  IDX_LIMIT_STATUS = 10'h04f;
	localparam logic [9:0]  IDX_PIN_STATUS   = 10'h050;
	localparam logic [9:0]  IDX_FAN_STATUS   = 10'h051;
	localparam logic [9:0]  IDX_CTRL         = 10'h060;
	localparam logic [9:0]  IDX_DUTY_LIMIT   = 10'h061;
	localparam logic [9:0]  IDX_LOCAL_LIMIT  = 10'h062;
	localparam logic [9:0]  IDX_REMOTE_LIMIT = 10'h063;
	localparam logic [9:0]  IDX_HYST         = 10'h064;
	localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h065;
	localparam logic [9:0]  IDX_IRQ_MASK     = 10'h066;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_SOFT_RST = 0;
	localparam int CTRL_WIN_LO   = 1;
	localparam int CTRL_DRIVE_EN = 3;
	localparam int S2_LOCAL_PIN  = 7;
	localparam int S2_REMOTE_PIN = 6;
	localparam int S2_EXCEEDED   = 4;
	localparam int S2_EXTERNAL   = 3;
	localparam int S2_INTERNAL   = 2;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_STATUS     = 8'h00;
	localparam logic [7:0] RST_CTRL       = 8'h08;
	localparam logic [7:0] RST_DUTY_LIMIT = 8'hff;
	localparam logic [7:0] RST_PIN_LIMIT  = 8'h55;
	localparam logic [3:0] RST_HYST       = 4'h5;
	localparam logic [7:0] RST_MASK       = 8'h00;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [11:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [11:0] araddr;
		logic        arvalid;
		logic        rready;
	} tfsb_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} tfsb_axi_rsp_s;

	typedef struct packed {
		logic       local_high;
		logic       local_low;
		logic       remote_high;
		logic       remote_low;
		logic       conv_done;
		logic       diode_fault;
		logic       fan_stall;
		logic       fan_alarm;
		logic       alert_low;
		logic [7:0] local_temp;
		logic [7:0] remote_temp;
	} tfsb_sense_s;

endpackage

//--- rtl/tfsb_bank.sv
// thermal and fan status bank with duty-cycle meter, axi4-lite slave and interrupt
// Contract
// - read-only percent on-time of overtemp pin
// - status1 bits 7,6 local high/low trips
// - status1 bits 5,4 remote high/low trips
// - remote diode fault sampled each conversion, bit3
// - status2 bit7 local pin limit crossed
// - status2 bit6 remote pin limit crossed
// - status2 bit4 duty limit exceeded
// - read clears exceeded; zero limit re-sets
// - status2 bit3 pin pulled low externally
// - status2 bit2 device drives pin low
// - status3 bit7 fan stalled
// - status3 bit6 alarm forces full speed
// - status3 bit0 alert output held low
// - status registers reset to zero, power-on/soft
// - pin release below limit minus hysteresis
//
// Our own choice: the AXI4-Lite register port.
module tfsb_bank #(
	parameter int SLICE_CYCLES = tfsb_pkg::SLICE_CYCLES
) (
	// clock and reset
	input  logic                    i_ref_clk,
	input  logic                    i_resetn,
	// register bus
	input  tfsb_pkg::tfsb_axi_req_s i_axi,
	output tfsb_pkg::tfsb_axi_rsp_s o_axi,
	// measurement engines
	input  tfsb_pkg::tfsb_sense_s   i_sense,
	// overtemp pin, open drain
	input  logic                    i_overtemp_pin,
	output logic                    o_overtemp_pin_out,
	output logic                    o_overtemp_pin_oe,
	// fan and interrupt
	output logic                    o_fan_full_speed,
	output logic                    o_irq
);

	localparam int CW = $clog2(SLICE_CYCLES * 8 + 1);
	localparam logic [6:0] LAST_SLICE = 7'(tfsb_pkg::PCT_SLICES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [9:0]  aw_idx;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  w_byte;
	logic        w_lane;
	logic        wr_fire;
	logic        rd_fire;
	logic [9:0]  rd_idx;
	logic [7:0]  rd_val;
	logic        rd_hit;
	logic        wr_hit;
	logic        wr_rsp_valid;
	logic [1:0]  wr_rsp_code;
	logic        rd_rsp_valid;
	logic [7:0]  rd_rsp_data;
	logic [1:0]  rd_rsp_code;
	logic        sw_rst;
	logic [7:0]  ctrl;
	logic [7:0]  duty_limit_setting;
	logic [7:0]  local_limit;
	logic [7:0]  remote_limit;
	logic [3:0]  hyst;
	logic [7:0]  irq_mask;
	logic [7:0]  irq_status;
	logic [7:0]  irq_cond;
	logic [7:0]  irq_prev;
	logic [7:0]  limit_status;
	logic [7:0]  overtemp_duty_value;
	logic        duty_limit_exceeded_flag;
	logic        local_pin_limit_flag;
	logic        remote_pin_limit_flag;
	logic        pin_driven_externally_flag;
	logic        fan_stalled;
	logic        fan_alarm_speed;
	logic        alert_low;
	logic        pin_s1;
	logic        pin_s2;
	logic        pin_low;
	logic [2:0]  drv_hist;
	logic        next_drive;
	logic [CW-1:0] slice_max;
	logic [CW-1:0] slice_cnt;
	logic [CW-1:0] act_cnt;
	logic [6:0]  slice_idx;
	logic [7:0]  pct_run;
	logic [7:0]  next_pct;
	logic        act_wrap;
	logic [1:0]  win_sel;
	logic [1:0]  win_prev;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel
	// one driver for the whole struct: mixed drivers on one packed variable are illegal
	assign o_axi = '{
		awready: !aw_held && !wr_rsp_valid,
		wready:  !w_held && !wr_rsp_valid,
		bresp:   wr_rsp_code,
		bvalid:  wr_rsp_valid,
		arready: !rd_rsp_valid,
		rdata:   {24'h000000, rd_rsp_data},
		rresp:   rd_rsp_code,
		rvalid:  rd_rsp_valid
	};
	assign wr_fire       = aw_held && w_held && !wr_rsp_valid;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held <= 1'b0;
			aw_idx  <= 10'h000;
		end else if (i_axi.awvalid && o_axi.awready) begin
			aw_held <= 1'b1;
			aw_idx  <= i_axi.awaddr[11:2];
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end else if (i_axi.wvalid && o_axi.wready) begin
			w_held <= 1'b1;
			w_byte <= i_axi.wdata[7:0];
			w_lane <= i_axi.wstrb[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		case (aw_idx)
			tfsb_pkg::IDX_ON_TIME,
			tfsb_pkg::IDX_LIMIT_STATUS,
			tfsb_pkg::IDX_PIN_STATUS,
			tfsb_pkg::IDX_FAN_STATUS,
			tfsb_pkg::IDX_CTRL,
			tfsb_pkg::IDX_DUTY_LIMIT,
			tfsb_pkg::IDX_LOCAL_LIMIT,
			tfsb_pkg::IDX_REMOTE_LIMIT,
			tfsb_pkg::IDX_HYST,
			tfsb_pkg::IDX_IRQ_STATUS,
			tfsb_pkg::IDX_IRQ_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_rsp_valid <= 1'b0;
			wr_rsp_code  <= tfsb_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			wr_rsp_valid <= 1'b1;
			wr_rsp_code  <= wr_hit ? tfsb_pkg::RESP_OKAY : tfsb_pkg::RESP_SLVERR;
		end else if (i_axi.bready) begin
			wr_rsp_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers; status registers ignore writes
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl               <= tfsb_pkg::RST_CTRL;
			duty_limit_setting <= tfsb_pkg::RST_DUTY_LIMIT;
			local_limit        <= tfsb_pkg::RST_PIN_LIMIT;
			remote_limit       <= tfsb_pkg::RST_PIN_LIMIT;
			hyst               <= tfsb_pkg::RST_HYST;
			irq_mask           <= tfsb_pkg::RST_MASK;
		end else if (wr_fire && w_lane) begin
			case (aw_idx)
				tfsb_pkg::IDX_CTRL:         ctrl <= w_byte & 8'h0e;
				tfsb_pkg::IDX_DUTY_LIMIT:   duty_limit_setting <= w_byte;
				tfsb_pkg::IDX_LOCAL_LIMIT:  local_limit <= w_byte;
				tfsb_pkg::IDX_REMOTE_LIMIT: remote_limit <= w_byte;
				tfsb_pkg::IDX_HYST:         hyst <= w_byte[3:0];
				tfsb_pkg::IDX_IRQ_MASK:     irq_mask <= w_byte;
				default: ;
			endcase
		end
	end

	// soft reset pulse, one cycle after the write
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sw_rst <= 1'b0;
		end else begin
			sw_rst <= wr_fire && w_lane && aw_idx == tfsb_pkg::IDX_CTRL
				&& w_byte[tfsb_pkg::CTRL_SOFT_RST];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel
	assign rd_fire       = i_axi.arvalid && o_axi.arready;
	assign rd_idx        = i_axi.araddr[11:2];

	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			tfsb_pkg::IDX_ON_TIME:      rd_val = overtemp_duty_value;
			tfsb_pkg::IDX_LIMIT_STATUS: rd_val = limit_status;
			tfsb_pkg::IDX_PIN_STATUS:   rd_val = {local_pin_limit_flag,
				remote_pin_limit_flag, 1'b0, duty_limit_exceeded_flag,
				pin_driven_externally_flag, o_overtemp_pin_oe, 2'b00};
			tfsb_pkg::IDX_FAN_STATUS:   rd_val = {fan_stalled, fan_alarm_speed,
				5'b00000, alert_low};
			tfsb_pkg::IDX_CTRL:         rd_val = ctrl;
			tfsb_pkg::IDX_DUTY_LIMIT:   rd_val = duty_limit_setting;
			tfsb_pkg::IDX_LOCAL_LIMIT:  rd_val = local_limit;
			tfsb_pkg::IDX_REMOTE_LIMIT: rd_val = remote_limit;
			tfsb_pkg::IDX_HYST:         rd_val = {4'h0, hyst};
			tfsb_pkg::IDX_IRQ_STATUS:   rd_val = irq_status;
			tfsb_pkg::IDX_IRQ_MASK:     rd_val = irq_mask;
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_rsp_valid <= 1'b0;
			rd_rsp_data  <= 8'h00;
			rd_rsp_code  <= tfsb_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rd_rsp_valid <= 1'b1;
			rd_rsp_data  <= rd_val;
			rd_rsp_code  <= rd_hit ? tfsb_pkg::RESP_OKAY : tfsb_pkg::RESP_SLVERR;
		end else if (i_axi.rready) begin
			rd_rsp_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// overtemp pin synchroniser and drive
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end else begin
			pin_s1 <= i_overtemp_pin;
			pin_s2 <= pin_s1;
		end
	end

	assign pin_low            = !pin_s2;
	assign o_overtemp_pin_out = 1'b0;
	assign next_drive         = (local_pin_limit_flag || remote_pin_limit_flag)
		&& ctrl[tfsb_pkg::CTRL_DRIVE_EN];

	// flag an external low only after our own drive has left the synchroniser
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_overtemp_pin_oe          <= 1'b0;
			drv_hist                   <= 3'b000;
			pin_driven_externally_flag <= 1'b0;
		end else if (sw_rst) begin
			o_overtemp_pin_oe          <= 1'b0;
			drv_hist                   <= 3'b000;
			pin_driven_externally_flag <= 1'b0;
		end else begin
			o_overtemp_pin_oe          <= next_drive;
			drv_hist                   <= {drv_hist[1:0], o_overtemp_pin_oe};
			pin_driven_externally_flag <= pin_low && !o_overtemp_pin_oe
				&& drv_hist == 3'b000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin limit comparison with hysteresis
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			local_pin_limit_flag <= 1'b0;
		end else if (sw_rst) begin
			local_pin_limit_flag <= 1'b0;
		end else if (i_sense.local_temp >= local_limit) begin
			local_pin_limit_flag <= 1'b1;
		end else if ({1'b0, i_sense.local_temp} + {5'b00000, hyst}
			< {1'b0, local_limit}) begin
			local_pin_limit_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			remote_pin_limit_flag <= 1'b0;
		end else if (sw_rst) begin
			remote_pin_limit_flag <= 1'b0;
		end else if (i_sense.remote_temp >= remote_limit) begin
			remote_pin_limit_flag <= 1'b1;
		end else if ({1'b0, i_sense.remote_temp} + {5'b00000, hyst}
			< {1'b0, remote_limit}) begin
			remote_pin_limit_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// limit and fan status
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			limit_status <= tfsb_pkg::RST_STATUS;
		end else if (sw_rst) begin
			limit_status <= tfsb_pkg::RST_STATUS;
		end else begin
			limit_status[7]   <= i_sense.local_high;
			limit_status[6]   <= i_sense.local_low;
			limit_status[5]   <= i_sense.remote_high;
			limit_status[4]   <= i_sense.remote_low;
			if (i_sense.conv_done) begin
				limit_status[3] <= i_sense.diode_fault;
			end
			limit_status[2:0] <= 3'b000;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fan_stalled     <= 1'b0;
			fan_alarm_speed <= 1'b0;
			alert_low       <= 1'b0;
		end else if (sw_rst) begin
			fan_stalled     <= 1'b0;
			fan_alarm_speed <= 1'b0;
			alert_low       <= 1'b0;
		end else begin
			fan_stalled     <= i_sense.fan_stall;
			fan_alarm_speed <= i_sense.fan_alarm || local_pin_limit_flag
				|| remote_pin_limit_flag;
			alert_low       <= i_sense.alert_low;
		end
	end

	assign o_fan_full_speed = fan_alarm_speed;

	////////////////////////////////////////////////////////////////////////////////
	// duty-cycle meter: window of 100 slices, one percent per slice of active time
	assign win_sel   = ctrl[tfsb_pkg::CTRL_WIN_LO +: 2];
	assign slice_max = (CW'(SLICE_CYCLES) << win_sel) - CW'(1);
	assign act_wrap  = pin_low && act_cnt == slice_max;
	assign next_pct  = pct_run + {7'h00, act_wrap};

	// a new window length restarts the window, so no mixed-length result
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			slice_cnt           <= '0;
			act_cnt             <= '0;
			slice_idx           <= 7'h00;
			pct_run             <= 8'h00;
			win_prev            <= 2'b00;
			overtemp_duty_value <= tfsb_pkg::RST_STATUS;
		end else if (sw_rst || win_sel != win_prev) begin
			slice_cnt           <= '0;
			act_cnt             <= '0;
			slice_idx           <= 7'h00;
			pct_run             <= 8'h00;
			win_prev            <= win_sel;
			if (sw_rst) begin
				overtemp_duty_value <= tfsb_pkg::RST_STATUS;
			end
		end else if (slice_cnt == slice_max && slice_idx == LAST_SLICE) begin
			slice_cnt           <= '0;
			act_cnt             <= '0;
			slice_idx           <= 7'h00;
			pct_run             <= 8'h00;
			overtemp_duty_value <= next_pct;
		end else begin
			if (slice_cnt == slice_max) begin
				slice_cnt <= '0;
				slice_idx <= slice_idx + 7'h01;
			end else begin
				slice_cnt <= slice_cnt + CW'(1);
			end
			if (act_wrap) begin
				act_cnt <= '0;
			end else if (pin_low) begin
				act_cnt <= act_cnt + CW'(1);
			end
			pct_run <= next_pct;
		end
	end

	// set wins over the clearing read
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			duty_limit_exceeded_flag <= 1'b0;
		end else if (sw_rst) begin
			duty_limit_exceeded_flag <= 1'b0;
		end else if (pct_run > duty_limit_setting) begin
			duty_limit_exceeded_flag <= 1'b1;
		end else if (duty_limit_setting == 8'h00 && pin_low) begin
			duty_limit_exceeded_flag <= 1'b1;
		end else if (rd_fire && rd_idx == tfsb_pkg::IDX_PIN_STATUS) begin
			duty_limit_exceeded_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt: rising conditions set sticky bits, read of status clears
	assign irq_cond = {alert_low, fan_alarm_speed, fan_stalled,
		pin_driven_externally_flag, duty_limit_exceeded_flag,
		local_pin_limit_flag || remote_pin_limit_flag, limit_status[3],
		|limit_status[7:4]};

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_prev   <= 8'h00;
			irq_status <= tfsb_pkg::RST_STATUS;
		end else if (sw_rst) begin
			irq_prev   <= 8'h00;
			irq_status <= tfsb_pkg::RST_STATUS;
		end else begin
			irq_prev <= irq_cond;
			if (rd_fire && rd_idx == tfsb_pkg::IDX_IRQ_STATUS) begin
				irq_status <= irq_cond & ~irq_prev;
			end else begin
				irq_status <= irq_status | (irq_cond & ~irq_prev);
			end
		end
	end

	assign o_irq = |(irq_status & irq_mask);

endmodule

//--- verif/tfsb_bank_properties.sv
// checker: bus timing, reserved bits and pin relations of the status bank
module tfsb_bank_chk #(
	parameter int SLICE_CYCLES = 4
) (
	// clock and reset
	input wire logic                    i_ref_clk,
	input wire logic                    i_resetn,
	// register bus
	input wire tfsb_pkg::tfsb_axi_req_s i_axi,
	input wire tfsb_pkg::tfsb_axi_rsp_s o_axi,
	// pin and fan
	input wire logic                    o_overtemp_pin_out,
	input wire logic                    o_overtemp_pin_oe,
	input wire logic                    o_fan_full_speed
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	// index of the read now answered; arready stays low while rvalid is up
	logic [9:0] rd_idx;
	logic       mapped;
	logic [7:0] rsv;
	assign mapped = (rd_idx >= tfsb_pkg::IDX_ON_TIME && rd_idx <= tfsb_pkg::IDX_FAN_STATUS)
		|| (rd_idx >= tfsb_pkg::IDX_CTRL && rd_idx <= tfsb_pkg::IDX_IRQ_MASK);
	assign rsv = (rd_idx == tfsb_pkg::IDX_LIMIT_STATUS) ? 8'h07 :
		(rd_idx == tfsb_pkg::IDX_PIN_STATUS) ? 8'h23 :
		(rd_idx == tfsb_pkg::IDX_FAN_STATUS) ? 8'h3e : 8'h00;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn)
			rd_idx <= 10'h000;
		else if (i_axi.arvalid && o_axi.arready)
			rd_idx <= i_axi.araddr[11:2];
	end
	////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	chk_read_latency: assert property (
		i_axi.arvalid && o_axi.arready |=> o_axi.rvalid) else $error("read answer late");
	chk_read_hold: assert property (
		o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
		else $error("read data not held");
	chk_write_latency: assert property (
		i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |-> ##2 o_axi.bvalid)
		else $error("write answer late");
	chk_write_hold: assert property (
		o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
		else $error("write response not held");
	chk_refuse_busy: assert property (
		o_axi.bvalid |-> !o_axi.awready && !o_axi.wready) else $error("accepted while busy");
	chk_reserved_zero: assert property (
		o_axi.rvalid |-> o_axi.rdata[31:8] == 24'h0 && (o_axi.rdata[7:0] & rsv) == 8'h00)
		else $error("reserved bits set");
	chk_unmapped_err: assert property (
		o_axi.rvalid && !mapped |-> o_axi.rresp == tfsb_pkg::RESP_SLVERR && o_axi.rdata == 0)
		else $error("unmapped read not refused");
	chk_mapped_okay: assert property (
		o_axi.rvalid && mapped |-> o_axi.rresp == tfsb_pkg::RESP_OKAY)
		else $error("mapped read refused");
	chk_pin_out_low: assert property (
		o_overtemp_pin_out == 1'b0 && (!o_overtemp_pin_oe || o_fan_full_speed))
		else $error("pin driven high or drive without alarm speed");
	chk_oe_alarm: assert property (
		$rose(o_overtemp_pin_oe) |-> ##[0:2] o_fan_full_speed) else $error("no alarm speed");
	cover property (o_axi.bvalid && i_axi.bready);
	cover property (o_axi.rvalid && !mapped);
	cover property ($rose(o_overtemp_pin_oe));
endmodule

bind tfsb_bank tfsb_bank_chk #(.SLICE_CYCLES(SLICE_CYCLES)) u_chk (
	.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_axi(i_axi), .o_axi(o_axi),
	.o_overtemp_pin_out(o_overtemp_pin_out), .o_overtemp_pin_oe(o_overtemp_pin_oe),
	.o_fan_full_speed(o_fan_full_speed));

//--- verif/tfsb_host.sv
// host model: axi4-lite master polling and writing the status bank
module tfsb_host (
	// clock
	input  wire logic                    i_ref_clk,
	// bus
	input  wire tfsb_pkg::tfsb_axi_rsp_s i_rsp,
	output tfsb_pkg::tfsb_axi_req_s      o_req
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	initial o_req = '0;
	// readies only move after a rising edge; the falling edge shows what the next one samples
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge i_ref_clk);
		o_req.awaddr <= {idx, 2'h0};
		o_req.wdata <= {24'h0, d};
		o_req.wstrb <= 4'h1;
		o_req.awvalid <= 1'b1;
		o_req.wvalid <= 1'b1;
		o_req.bready <= 1'b1;
		while (aw || w) begin
			@(negedge i_ref_clk);
			aw = aw && !i_rsp.awready;
			w = w && !i_rsp.wready;
			@(posedge i_ref_clk);
			if (!aw) o_req.awvalid <= 1'b0;
			if (!w) o_req.wvalid <= 1'b0;
		end
		do @(negedge i_ref_clk); while (!i_rsp.bvalid);
		resp = i_rsp.bresp;
		@(posedge i_ref_clk);
		o_req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] resp);
		@(posedge i_ref_clk);
		o_req.araddr <= {idx, 2'h0};
		o_req.arvalid <= 1'b1;
		o_req.rready <= 1'b1;
		do @(negedge i_ref_clk); while (!i_rsp.arready);
		@(posedge i_ref_clk);
		o_req.arvalid <= 1'b0;
		do @(negedge i_ref_clk); while (!i_rsp.rvalid);
		d = i_rsp.rdata[7:0];
		resp = i_rsp.rresp;
		@(posedge i_ref_clk);
		o_req.rready <= 1'b0;
	endtask
endmodule

//--- verif/thermal_fan_status_bank_test.sv
// testbench: drives sensing and pin, checks the bank against expected values
module thermal_fan_status_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLICE = 4;
	logic                    clk;
	logic                    resetn;
	tfsb_pkg::tfsb_axi_req_s req;
	tfsb_pkg::tfsb_axi_rsp_s rsp;
	tfsb_pkg::tfsb_sense_s   sn;
	logic                    ext_low;
	logic                    oe;
	logic                    pin_out;
	logic                    fan_full;
	logic                    irq;
	wire logic               pin;
	int                      n_fail;
	int                      cmp_count;
	int                      cycles;
	logic [7:0]              d;
	logic [1:0]              r;
	logic [31:0]             v;
	logic [9:0]              ro[4];
	logic [7:0]              tq[4];
	logic                    fq[4];
	////////////////////////////////////////
	// open drain with pull-up: low when either party pulls
	assign pin = !(ext_low || (oe && !pin_out));
	initial clk = 1'b0;
	always #2 clk = ~clk;
	tfsb_bank #(.SLICE_CYCLES(SLICE)) DUT (.i_ref_clk(clk), .i_resetn(resetn), .i_axi(req),
		.o_axi(rsp), .i_sense(sn), .i_overtemp_pin(pin), .o_overtemp_pin_out(pin_out),
		.o_overtemp_pin_oe(oe), .o_fan_full_speed(fan_full), .o_irq(irq));
	tfsb_host u_host (.i_ref_clk(clk), .i_rsp(rsp), .o_req(req));
	////////////////////////////////////////
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e,
		input logic [1:0] er = tfsb_pkg::RESP_OKAY);
		u_host.rd(i, d, r);
		cmp(d, e, "read data");
		cmp({6'h0, r}, {6'h0, er}, "read resp");
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] val);
		u_host.wr(i, val, r);
		cmp({6'h0, r}, {6'h0, tfsb_pkg::RESP_OKAY}, "write resp");
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a hang shows up as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	////////////////////////////////////////
	initial begin
		ro = '{tfsb_pkg::IDX_ON_TIME, tfsb_pkg::IDX_LIMIT_STATUS, tfsb_pkg::IDX_PIN_STATUS,
			tfsb_pkg::IDX_FAN_STATUS};
		tq = '{8'h54, 8'h55, 8'h50, 8'h4f};
		fq = '{1'b0, 1'b1, 1'b1, 1'b0};
		void'($urandom(92));
		resetn = 1'b0;
		sn = '0;
		ext_low = 1'b0;
		wait_n(3);
		resetn <= 1'b1;
		foreach (ro[i]) rd(ro[i], 8'h00);
		wr(tfsb_pkg::IDX_LIMIT_STATUS, 8'hff);
		rd(tfsb_pkg::IDX_LIMIT_STATUS, 8'h00);
		rd(10'h3ff, 8'h00, tfsb_pkg::RESP_SLVERR);
		// random trips; temperatures kept under the pin limit
		for (int k = 0; k < 8; k++) begin
			v = $urandom;
			@(posedge clk);
			sn <= {v[3:0], 1'b1, v[7], v[4], v[5], v[6], v[15:8] & 8'h3f, v[23:16] & 8'h3f};
			@(posedge clk);
			sn.conv_done <= 1'b0;
			wait_n(3);
			rd(tfsb_pkg::IDX_LIMIT_STATUS, {v[3:0], v[7], 3'h0});
			rd(tfsb_pkg::IDX_FAN_STATUS, {v[4], v[5], 5'h0, v[6]});
			cmp({7'h0, irq}, 8'h00, "masked irq");
		end
		@(posedge clk);
		sn <= '0;
		for (int ch = 0; ch < 2; ch++) begin
			foreach (tq[i]) begin
				@(posedge clk);
				if (ch == 0) sn.local_temp <= tq[i];
				else sn.remote_temp <= tq[i];
				wait_n(4);
				rd(tfsb_pkg::IDX_PIN_STATUS,
					{ch == 0 && fq[i], ch == 1 && fq[i], 3'h0, fq[i], 2'h0});
				cmp({7'h0, fan_full}, {7'h0, fq[i]}, "alarm speed");
			end
		end
		@(posedge clk);
		ext_low <= 1'b1;
		wait_n(8);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h08);
		wr(tfsb_pkg::IDX_DUTY_LIMIT, 8'h00);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h18);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h18);
		@(posedge clk);
		ext_low <= 1'b0;
		wait_n(8);
		// nonzero limit, else the running percent of this window sets the flag again
		wr(tfsb_pkg::IDX_DUTY_LIMIT, 8'hff);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h10);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h00);
		// pin held low over more than two whole windows
		wr(tfsb_pkg::IDX_DUTY_LIMIT, 8'h0a);
		@(posedge clk);
		ext_low <= 1'b1;
		wait_n(1000);
		rd(tfsb_pkg::IDX_ON_TIME, 8'h64);
		rd(tfsb_pkg::IDX_PIN_STATUS, 8'h18);
		wr(tfsb_pkg::IDX_CTRL, 8'h09);
		rd(tfsb_pkg::IDX_ON_TIME, 8'h00);
		rd(tfsb_pkg::IDX_CTRL, 8'h08);
		rd(tfsb_pkg::IDX_DUTY_LIMIT, 8'h0a);
		@(posedge clk);
		ext_low <= 1'b0;
		wait_n(1000);
		rd(tfsb_pkg::IDX_ON_TIME, 8'h00);
		u_host.rd(tfsb_pkg::IDX_IRQ_STATUS, d, r);
		wr(tfsb_pkg::IDX_IRQ_MASK, 8'h20);
		@(posedge clk);
		sn.fan_stall <= 1'b1;
		wait_n(4);
		cmp({7'h0, irq}, 8'h01, "irq raised");
		rd(tfsb_pkg::IDX_IRQ_STATUS, 8'h20);
		wait_n(2);
		cmp({7'h0, irq}, 8'h00, "irq cleared");
		wr(tfsb_pkg::IDX_IRQ_MASK, 8'h00);
		@(posedge clk);
		sn.fan_stall <= 1'b0;
		wait_n(2);
		sn.fan_stall <= 1'b1;
		wait_n(4);
		cmp({7'h0, irq}, 8'h00, "irq masked");
		rd(tfsb_pkg::IDX_IRQ_MASK, 8'h00);
		end_sim();
	end
endmodule
